// >>> hw/dcc_pkg.sv
// Shared constants and types for the four-channel transfer controller
package dcc_pkg;
    localparam int DCC_CHANNELS = 4;
    localparam int DCC_ADDR_W = 8;
    // Per-channel register word offsets (byte address = chan * stride + offset)
    localparam logic [7:0] DCC_CHAN_STRIDE = 8'h20;
    localparam logic [4:0] DCC_OFS_CON = 5'h00;
    localparam logic [4:0] DCC_OFS_REQ = 5'h04;
    localparam logic [4:0] DCC_OFS_STAH = 5'h08;
    localparam logic [4:0] DCC_OFS_STAL = 5'h0c;
    localparam logic [4:0] DCC_OFS_STBH = 5'h10;
    localparam logic [4:0] DCC_OFS_STBL = 5'h14;
    localparam logic [4:0] DCC_OFS_PAD = 5'h18;
    localparam logic [4:0] DCC_OFS_CNT = 5'h1c;
    // Shared status registers
    localparam logic [7:0] DCC_OFS_WCOL = 8'h80;
    localparam logic [7:0] DCC_OFS_RQCOL = 8'h84;
    localparam logic [7:0] DCC_OFS_PPST = 8'h88;
    localparam logic [7:0] DCC_OFS_LAST_CH = 8'h8c;
    localparam logic [7:0] DCC_OFS_SADR_H = 8'h90;
    localparam logic [7:0] DCC_OFS_SADR_L = 8'h94;
    // Control register fields
    localparam int DCC_CON_EN = 15;
    localparam int DCC_CON_BYTE = 14;
    localparam int DCC_CON_DIR = 13;
    localparam int DCC_CON_HALF = 12;
    localparam int DCC_CON_NULL_WRITE_SELECT = 11;
    localparam int DCC_CON_ADDRESSING_MODE_SELECT = 4;
    localparam int DCC_CON_MODE = 0;
    localparam logic [15:0] DCC_CON_MASK = 16'hf833;
    localparam logic [15:0] DCC_CON_RESET = 16'h0000;
    // Trigger select fields
    localparam int DCC_REQ_FORCE = 15;
    localparam logic [7:0] DCC_REQ_SEL_RESET = 8'h00;
    localparam logic [3:0] DCC_LAST_CH_RESET = 4'hf;
    localparam int DCC_CNT_W = 14;
    // Addressing modes
    localparam logic [1:0] DCC_AM_POSTINC = 2'h0;
    localparam logic [1:0] DCC_AM_NOINC = 2'h1;
    localparam logic [1:0] DCC_AM_PERIPH = 2'h2;

    // One element move handed to the bus arbiter
    typedef struct packed {
        logic [23:0] sram_addr;
        logic [15:0] periph_addr;
        logic to_periph;
        logic byte_size;
        logic null_write;
        logic [1:0] chan;
    } dcc_xfer_type;

    typedef enum logic {DCC_ST_IDLE, DCC_ST_BUSY} dcc_state_type;
endpackage

// >>> hw/dcc_arbiter.sv
// Fixed-priority grant among pending channels
`timescale 1ns/1ps
`default_nettype none
module dcc_arbiter #(
    parameter int CHANNELS = 4
) (
    input wire logic [CHANNELS-1:0] pend_in, // Pending channel requests
    output logic valid_out, // Some channel pending
    output logic [1:0] chan_out // Granted channel
);
    // Lowest number wins; scan from the top so the last hit is lowest
    always_comb begin
        valid_out = |pend_in;
        chan_out = 2'h0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (pend_in[i]) begin
                chan_out = 2'(i);
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/dcc_top.sv
// Four-channel transfer control with Avalon-MM register slave
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - four independent channels, each full register set
// - 14-bit count, split high/low start addresses
// - shared collision, address, ping-pong, channel status
// - completion flags live in interrupt controller
// - control bit 15 enables channel, resets 0
// - control bit 14 selects byte or word
// - control bit 13 selects transfer direction
// - control bit 12 raises interrupt at half
// - bit 11 adds null peripheral write when bit 13 is clear
// - bits 5-4 select addressing mode
// - bits 1-0 select one-shot, continuous, ping-pong
// - unused control bits read zero
// - force bit starts one manual transfer
// - software cannot clear force; hardware does (here clearing control bit 15 also clears it)
// - bits 7-0 select request interrupt number
// - primary start address 24 bits, high/low
// - block moves count plus one elements
// - simultaneous requests granted by fixed priority
// - ping-pong alternates start address per block
module dcc_top
    import dcc_pkg::*;
(
    input wire logic sys_clk_in, // 100 MHz system clock
    input wire logic rst_in, // Synchronous reset, high
    input wire logic [dcc_pkg::DCC_ADDR_W-1:0] avs_address_in, // Byte address
    input wire logic avs_read_in, // Read strobe
    input wire logic avs_write_in, // Write strobe
    input wire logic [31:0] avs_writedata_in, // Write data
    output logic [31:0] avs_readdata_out, // Read data
    output logic avs_waitrequest_out, // Stall request
    input wire logic [255:0] irq_lines_in, // Peripheral request pulses
    input wire logic [15:0] periph_index_in, // Offset from peripheral
    input wire logic [3:0] wcol_in, // Peripheral write collision pulses
    output dcc_pkg::dcc_xfer_type xfer_out, // Element move
    output logic xfer_valid_out, // Move pending
    input wire logic xfer_ack_in, // Move completed
    output logic [3:0] block_irq_out // Block interrupt pulses
);
    import dcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [15:0] con_q [DCC_CHANNELS];
    logic [7:0] sel_q [DCC_CHANNELS];
    logic [3:0] force_q;
    logic [23:0] sta_q [DCC_CHANNELS];
    logic [23:0] stb_q [DCC_CHANNELS];
    logic [15:0] pad_q [DCC_CHANNELS];
    logic [DCC_CNT_W-1:0] cnt_q [DCC_CHANNELS];
    logic [DCC_CNT_W-1:0] done_q [DCC_CHANNELS];
    logic [23:0] ofs_q [DCC_CHANNELS];
    logic [3:0] pend_q, pp_q, wcol_q, rqcol_q;
    logic [3:0] last_ch_q;
    logic [23:0] sadr_q;
    logic wait_q;
    logic [31:0] rdata_q;
    dcc_xfer_type xfer_q;
    logic valid_q;
    logic [3:0] irq_q;
    dcc_state_type state_q;
    logic [1:0] cur_q;
    logic grant_valid;
    logic [1:0] grant_ch;
    logic done_now, blk_end, half_hit;
    logic wr_en, rd_en;
    logic [1:0] wr_ch;
    logic [4:0] wr_ofs;
    logic wr_chan_reg;

    // Step after one element: one for bytes, two for words
    function automatic logic [23:0] step_of(input logic [15:0] con);
        return con[DCC_CON_BYTE] ? 24'h00_0001 : 24'h00_0002;
    endfunction

    // Start address of the buffer in use
    function automatic logic [23:0] base_of(input int c);
        return pp_q[c] ? stb_q[c] : sta_q[c];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode: answer one cycle after the request, write at that edge
    assign wr_en = avs_write_in && !wait_q;
    assign rd_en = avs_read_in && wait_q;
    assign wr_ch = avs_address_in[6:5];
    assign wr_ofs = avs_address_in[4:0];
    assign wr_chan_reg = wr_en && !avs_address_in[7];

    // Wait state toggles low for exactly one edge per request
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read_in || avs_write_in) && wait_q);
        end
    end

    // Read data mux; reserved bits come out zero
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata_q <= 32'h0000_0000;
            if (!avs_address_in[7]) begin
                case (wr_ofs)
                    DCC_OFS_CON: rdata_q[15:0] <= con_q[wr_ch] & DCC_CON_MASK;
                    DCC_OFS_REQ: rdata_q[15:0] <= {force_q[wr_ch], 7'h00, sel_q[wr_ch]};
                    DCC_OFS_STAH: rdata_q[7:0] <= sta_q[wr_ch][23:16];
                    DCC_OFS_STAL: rdata_q[15:0] <= sta_q[wr_ch][15:0];
                    DCC_OFS_STBH: rdata_q[7:0] <= stb_q[wr_ch][23:16];
                    DCC_OFS_STBL: rdata_q[15:0] <= stb_q[wr_ch][15:0];
                    DCC_OFS_PAD: rdata_q[15:0] <= pad_q[wr_ch];
                    DCC_OFS_CNT: rdata_q[13:0] <= cnt_q[wr_ch];
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end else begin
                case (avs_address_in)
                    DCC_OFS_WCOL: rdata_q[3:0] <= wcol_q;
                    DCC_OFS_RQCOL: rdata_q[3:0] <= rqcol_q;
                    DCC_OFS_PPST: rdata_q[3:0] <= pp_q;
                    DCC_OFS_LAST_CH: rdata_q[3:0] <= last_ch_q;
                    DCC_OFS_SADR_H: rdata_q[7:0] <= sadr_q[23:16];
                    DCC_OFS_SADR_L: rdata_q[15:0] <= sadr_q[15:0];
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;

    ////////////////////////////////////////////////////////////////////////
    // Engine events
    assign done_now = (state_q == DCC_ST_BUSY) && xfer_ack_in;
    assign blk_end = done_now && (done_q[cur_q] == cnt_q[cur_q]);
    assign half_hit = done_now && (done_q[cur_q] == {1'b0, cnt_q[cur_q][DCC_CNT_W-1:1]});

    // Per-channel configuration registers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (int c = 0; c < DCC_CHANNELS; c++) begin
                con_q[c] <= DCC_CON_RESET;
                sel_q[c] <= DCC_REQ_SEL_RESET;
                sta_q[c] <= 24'h00_0000;
                stb_q[c] <= 24'h00_0000;
                pad_q[c] <= 16'h0000;
                cnt_q[c] <= '0;
            end
        end else begin
            // One-shot: drop enable after last block, after secondary in ping-pong
            if (blk_end && con_q[cur_q][DCC_CON_MODE] &&
                (!con_q[cur_q][DCC_CON_MODE+1] || pp_q[cur_q])) begin
                con_q[cur_q][DCC_CON_EN] <= 1'b0;
            end
            if (wr_chan_reg) begin
                case (wr_ofs)
                    DCC_OFS_CON: con_q[wr_ch] <= avs_writedata_in[15:0] & DCC_CON_MASK;
                    DCC_OFS_REQ: sel_q[wr_ch] <= avs_writedata_in[7:0];
                    DCC_OFS_STAH: sta_q[wr_ch][23:16] <= avs_writedata_in[7:0];
                    DCC_OFS_STAL: sta_q[wr_ch][15:0] <= avs_writedata_in[15:0];
                    DCC_OFS_STBH: stb_q[wr_ch][23:16] <= avs_writedata_in[7:0];
                    DCC_OFS_STBL: stb_q[wr_ch][15:0] <= avs_writedata_in[15:0];
                    DCC_OFS_PAD: pad_q[wr_ch] <= avs_writedata_in[15:0];
                    DCC_OFS_CNT: cnt_q[wr_ch] <= avs_writedata_in[DCC_CNT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Force, pending and request collision; a new set beats any clear except a disabled channel
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            force_q <= 4'h0;
            pend_q <= 4'h0;
            rqcol_q <= 4'h0;
        end else begin
            for (int c = 0; c < DCC_CHANNELS; c++) begin
                logic en, hw_req, sw_set, fin;
                en = con_q[c][DCC_CON_EN];
                hw_req = en && irq_lines_in[sel_q[c]];
                sw_set = wr_chan_reg && wr_ch == 2'(c) && wr_ofs == DCC_OFS_REQ &&
                    avs_writedata_in[DCC_REQ_FORCE];
                fin = done_now && cur_q == 2'(c);
                if (!en) begin
                    force_q[c] <= 1'b0;
                    pend_q[c] <= 1'b0;
                end else begin
                    // Software can only set; completion of forced move clears
                    force_q[c] <= sw_set || (force_q[c] && !fin);
                    pend_q[c] <= hw_req || sw_set || (pend_q[c] && !fin);
                end
                if ((sw_set && (hw_req || pend_q[c])) || (hw_req && force_q[c])) begin
                    rqcol_q[c] <= 1'b1;
                end else if (wr_en && avs_address_in == DCC_OFS_RQCOL && avs_writedata_in[c]) begin
                    rqcol_q[c] <= 1'b0;
                end
            end
        end
    end

    // Write collision flags: write one to clear, new event wins
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wcol_q <= 4'h0;
        end else begin
            for (int c = 0; c < DCC_CHANNELS; c++) begin
                if (wcol_in[c]) begin
                    wcol_q[c] <= 1'b1;
                end else if (wr_en && avs_address_in == DCC_OFS_WCOL && avs_writedata_in[c]) begin
                    wcol_q[c] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration among pending channels
    dcc_arbiter #(
        .CHANNELS(DCC_CHANNELS)
    ) u_arb (
        .pend_in(pend_q),
        .valid_out(grant_valid),
        .chan_out(grant_ch)
    );

    // Issue one element move at a time and wait for its acknowledge
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q <= DCC_ST_IDLE;
            valid_q <= 1'b0;
            cur_q <= 2'h0;
            xfer_q <= '0;
        end else begin
            case (state_q)
                DCC_ST_IDLE: begin
                    if (grant_valid) begin
                        logic [15:0] con;
                        con = con_q[grant_ch];
                        cur_q <= grant_ch;
                        valid_q <= 1'b1;
                        state_q <= DCC_ST_BUSY;
                        xfer_q.chan <= grant_ch;
                        xfer_q.periph_addr <= pad_q[grant_ch];
                        xfer_q.to_periph <= con[DCC_CON_DIR];
                        xfer_q.byte_size <= con[DCC_CON_BYTE];
                        xfer_q.null_write <= con[DCC_CON_NULL_WRITE_SELECT] && !con[DCC_CON_DIR];
                        case (con[DCC_CON_ADDRESSING_MODE_SELECT +: 2])
                            DCC_AM_NOINC: xfer_q.sram_addr <= base_of(grant_ch);
                            DCC_AM_PERIPH: xfer_q.sram_addr <= base_of(grant_ch) + {8'h00, periph_index_in};
                            default: xfer_q.sram_addr <= base_of(grant_ch) + ofs_q[grant_ch];
                        endcase
                    end
                end
                DCC_ST_BUSY: begin
                    if (xfer_ack_in) begin
                        valid_q <= 1'b0;
                        state_q <= DCC_ST_IDLE;
                    end
                end
                default: state_q <= DCC_ST_IDLE;
            endcase
        end
    end

    assign xfer_out = xfer_q;
    assign xfer_valid_out = valid_q;

    // Block progress, address offset and ping-pong buffer select
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (int c = 0; c < DCC_CHANNELS; c++) begin
                done_q[c] <= '0;
                ofs_q[c] <= 24'h00_0000;
            end
            pp_q <= 4'h0;
        end else if (wr_chan_reg && wr_ofs == DCC_OFS_CON) begin
            // Reprogramming restarts the block from the primary buffer
            done_q[wr_ch] <= '0;
            ofs_q[wr_ch] <= 24'h00_0000;
            pp_q[wr_ch] <= 1'b0;
        end else if (done_now) begin
            if (blk_end) begin
                done_q[cur_q] <= '0;
                ofs_q[cur_q] <= 24'h00_0000;
                if (con_q[cur_q][DCC_CON_MODE+1]) begin
                    pp_q[cur_q] <= !pp_q[cur_q];
                end
            end else begin
                done_q[cur_q] <= done_q[cur_q] + 1'b1;
                if (con_q[cur_q][DCC_CON_ADDRESSING_MODE_SELECT +: 2] == DCC_AM_POSTINC) begin
                    ofs_q[cur_q] <= ofs_q[cur_q] + step_of(con_q[cur_q]);
                end
            end
        end
    end

    // Block interrupt pulse to the interrupt controller, at half or end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_q <= 4'h0;
        end else begin
            irq_q <= 4'h0;
            if (con_q[cur_q][DCC_CON_HALF] ? half_hit : blk_end) begin
                irq_q[cur_q] <= 1'b1;
            end
        end
    end

    assign block_irq_out = irq_q;

    // Shared last-access status
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            last_ch_q <= DCC_LAST_CH_RESET;
            sadr_q <= 24'h00_0000;
        end else if (done_now) begin
            last_ch_q <= {2'b00, cur_q};
            sadr_q <= xfer_q.sram_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    AST_PRIO_CH0: assert property ((state_q == DCC_ST_IDLE) && pend_q[0] |=> valid_q && xfer_q.chan == 2'h0)
        else $error("channel 0 not granted first");
    AST_DISABLED_IDLE: assert property (!con_q[1][DCC_CON_EN] |=> !pend_q[1])
        else $error("disabled channel still pending");
    AST_CON_ZERO: assert property (avs_read_in && !wait_q && avs_address_in == 8'h20 |->
        avs_readdata_out[10:6] == 5'h00 && avs_readdata_out[3:2] == 2'h0)
        else $error("unused control bits not zero");
    AST_REQ_ZERO: assert property (avs_read_in && !wait_q && avs_address_in == 8'h24 |->
        avs_readdata_out[14:8] == 7'h00)
        else $error("unused trigger bits not zero");
    AST_FORCE_HOLD: assert property (force_q[0] && con_q[0][DCC_CON_EN] && !(done_now && cur_q == 2'h0)
        |=> force_q[0])
        else $error("force bit lost early");
    AST_BLOCK_WRAP: assert property (blk_end && cur_q == 2'h0 |=> done_q[0] == '0 && irq_q[0] == !con_q[0][12])
        else $error("block end mishandled");
    AST_PINGPONG: assert property (blk_end && cur_q == 2'h3 && con_q[3][1] && !wr_chan_reg
        |=> pp_q[3] != $past(pp_q[3]))
        else $error("ping-pong did not toggle");
    AST_ONESHOT: assert property (blk_end && cur_q == 2'h0 && con_q[0][1:0] == 2'h1 && !wr_chan_reg
        |=> !con_q[0][DCC_CON_EN])
        else $error("one-shot left channel on");
    AST_STEP: assert property (done_now && !blk_end && cur_q == 2'h0 && con_q[0][5:4] == 2'h0 && !wr_chan_reg
        |=> ofs_q[0] == $past(ofs_q[0]) + (con_q[0][14] ? 24'h00_0001 : 24'h00_0002))
        else $error("post-increment step wrong");
    AST_NULL_DIR: assert property ($rose(valid_q) |-> !(xfer_q.null_write && xfer_q.to_periph))
        else $error("null write with peripheral direction");
    AST_BUS_ANSWER: assert property ((avs_read_in || avs_write_in) && wait_q |=> !wait_q)
        else $error("bus answer late");

    COV_BLOCK: cover property (blk_end);
    COV_FORCE: cover property (force_q[0] ##[1:50] !force_q[0]);
    COV_PP: cover property (blk_end && con_q[cur_q][1]);
    COV_COLLIDE: cover property (grant_valid && pend_q[0] && pend_q[3]);
endmodule
`default_nettype wire

// >>> verif/dcc_arb_model.sv
// Behavioural bus arbiter that completes element moves
`timescale 1ns/1ps
`default_nettype none
module dcc_arb_model (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Synchronous reset
    input wire logic valid_in, // Move pending
    input wire logic [7:0] dly_in, // Stall cycles before ack
    output logic ack_out // Move completed
);
    logic [7:0] cnt_q;
    // Ack lasts one cycle; restart per move so a held valid never double-acks
    always_ff @(posedge clk_in) begin
        if (rst_in || !valid_in || ack_out) begin
            cnt_q <= 8'h00;
            ack_out <= 1'b0;
        end else if (cnt_q >= dly_in) begin
            ack_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the four-channel transfer control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dcc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [255:0] irq_lines_in = '0;
    logic [15:0] periph_index_in = 16'h0006;
    logic [3:0] wcol_in = 4'h0;
    dcc_xfer_type xfer_out;
    logic xfer_valid_out;
    logic xfer_ack_in;
    logic [3:0] block_irq_out;
    logic [7:0] ack_dly = 8'h00;
    logic [15:0] rd;
    int n_mismatch = 0;
    int compares = 0;
    int irq_cnt [4] = '{default: 0};
    int base;

    dcc_top dut (.sys_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .irq_lines_in, .periph_index_in, .wcol_in, .xfer_out,
        .xfer_valid_out, .xfer_ack_in, .block_irq_out);
    dcc_arb_model arb (.clk_in(sys_clk_in), .rst_in(rst_in), .valid_in(xfer_valid_out), .dly_in(ack_dly),
        .ack_out(xfer_ack_in));

    ////////////////////////////////////////////////////////////////////////
    // Clock and pulse tally
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        for (int i = 0; i < 4; i++) if (block_irq_out[i] === 1'b1) irq_cnt[i]++;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [7:0] ra(input logic [1:0] ch, input logic [4:0] ofs);
        return 8'(ch) * DCC_CHAN_STRIDE + 8'(ofs);
    endfunction
    // Request held until waitrequest low; extra edge keeps strobes from toggling twice
    task automatic bw(input logic [7:0] a, input logic [15:0] d);
        avs_address_in <= a;
        avs_writedata_in <= {16'h0000, d};
        avs_write_in <= 1'b1;
        do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
        avs_write_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic br(input logic [7:0] a);
        avs_address_in <= a;
        avs_read_in <= 1'b1;
        do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out[15:0];
        avs_read_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
        bw(a, d);
        br(a);
        chk("readback", 32'(rd), 32'(e));
    endtask
    // Wait for the completed move, then judge channel, address and flags
    task automatic mv(input logic [1:0] ch, input logic [23:0] ad, input logic [2:0] fl);
        int n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (!(xfer_valid_out === 1'b1 && xfer_ack_in === 1'b1) && n < 200);
        chk("move_seen", 32'(xfer_valid_out === 1'b1 && xfer_ack_in === 1'b1), 32'h0000_0001);
        chk("chan", 32'(xfer_out.chan), 32'(ch));
        chk("sram_addr", 32'(xfer_out.sram_addr), 32'(ad));
        chk("flags", 32'({xfer_out.to_periph, xfer_out.byte_size, xfer_out.null_write}), 32'(fl));
    endtask
    task automatic frc(input logic [1:0] ch, input logic [23:0] ad);
        bw(ra(ch, DCC_OFS_REQ), 16'h8000);
        mv(ch, ad, 3'h0);
        repeat (3) @(posedge sys_clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        br(ra(0, DCC_OFS_CON));
        chk("con", 32'(rd), 32'h0000_0000);
        br(ra(2, DCC_OFS_STBH));
        chk("stbh", 32'(rd), 32'h0000_0000);
        br(ra(2, DCC_OFS_STBL));
        chk("stbl", 32'(rd), 32'h0000_0000);
        br(DCC_OFS_LAST_CH);
        chk("last_ch", 32'(rd), 32'(DCC_LAST_CH_RESET));
    endtask
    task automatic t_fields;
        wr(ra(1, DCC_OFS_CON), 16'hffff, 16'hf833);
        wr(ra(1, DCC_OFS_CON), 16'h0000, 16'h0000);
        wr(ra(1, DCC_OFS_REQ), 16'h7fff, 16'h00ff);
        wr(ra(1, DCC_OFS_STAH), 16'hffff, 16'h00ff);
        wr(ra(1, DCC_OFS_STBH), 16'hffff, 16'h00ff);
        wr(ra(1, DCC_OFS_STBL), 16'ha5c3, 16'ha5c3);
        wr(8'hfc, 16'hffff, 16'h0000);
    endtask
    task automatic t_oneshot;
        bw(ra(0, DCC_OFS_STAH), 16'h0012);
        bw(ra(0, DCC_OFS_STAL), 16'h3400);
        bw(ra(0, DCC_OFS_CNT), 16'h0002);
        bw(ra(0, DCC_OFS_CON), 16'h8001);
        frc(0, 24'h12_3400);
        frc(0, 24'h12_3402);
        chk("irq0", 32'(irq_cnt[0]), 32'h0000_0000);
        frc(0, 24'h12_3404);
        chk("irq0", 32'(irq_cnt[0]), 32'h0000_0001);
        br(ra(0, DCC_OFS_CON));
        chk("con", 32'(rd), 32'h0000_0001);
    endtask
    task automatic t_force;
        ack_dly <= 8'h28;
        bw(ra(0, DCC_OFS_CON), 16'h8000);
        bw(ra(0, DCC_OFS_REQ), 16'h8000);
        bw(ra(0, DCC_OFS_REQ), 16'h0000);
        // Request line hit while forced counts as a collision
        irq_lines_in <= 256'h1;
        @(posedge sys_clk_in);
        irq_lines_in <= '0;
        br(DCC_OFS_RQCOL);
        chk("rqcol", 32'(rd), 32'h0000_0001);
        wr(DCC_OFS_RQCOL, 16'h0001, 16'h0000);
        br(ra(0, DCC_OFS_REQ));
        chk("force", 32'(rd), 32'h0000_8000);
        mv(0, 24'h12_3400, 3'h0);
        repeat (3) @(posedge sys_clk_in);
        br(ra(0, DCC_OFS_REQ));
        chk("force", 32'(rd), 32'h0000_0000);
        ack_dly <= 8'h00;
    endtask
    task automatic t_half;
        bw(ra(0, DCC_OFS_CNT), 16'h0003);
        bw(ra(0, DCC_OFS_CON), 16'h9000);
        base = irq_cnt[0];
        frc(0, 24'h12_3400);
        frc(0, 24'h12_3402);
        chk("irq_half", 32'(irq_cnt[0] - base), 32'h0000_0001);
        frc(0, 24'h12_3404);
        frc(0, 24'h12_3406);
        chk("irq_half", 32'(irq_cnt[0] - base), 32'h0000_0001);
    endtask
    task automatic t_prio;
        bw(ra(1, DCC_OFS_STAH), 16'h0000);
        bw(ra(1, DCC_OFS_STAL), 16'h0040);
        bw(ra(1, DCC_OFS_REQ), 16'h0005);
        bw(ra(1, DCC_OFS_CON), 16'he010);
        bw(ra(2, DCC_OFS_STAL), 16'h0080);
        bw(ra(2, DCC_OFS_REQ), 16'h0006);
        bw(ra(2, DCC_OFS_PAD), 16'h0268);
        bw(ra(2, DCC_OFS_CON), 16'h8820);
        irq_lines_in <= 256'h60;
        @(posedge sys_clk_in);
        irq_lines_in <= '0;
        mv(1, 24'h00_0040, 3'h6);
        mv(2, 24'h00_0086, 3'h1);
        chk("periph_addr", 32'(xfer_out.periph_addr), 32'h0000_0268);
        irq_lines_in <= 256'h20;
        @(posedge sys_clk_in);
        irq_lines_in <= '0;
        mv(1, 24'h00_0040, 3'h6);
        br(DCC_OFS_LAST_CH);
        chk("last_ch", 32'(rd), 32'h0000_0001);
        br(DCC_OFS_SADR_L);
        chk("sadr_l", 32'(rd), 32'h0000_0040);
        // Write collision latches until written one
        wcol_in <= 4'h4;
        @(posedge sys_clk_in);
        wcol_in <= 4'h0;
        br(DCC_OFS_WCOL);
        chk("wcol", 32'(rd), 32'h0000_0004);
        wr(DCC_OFS_WCOL, 16'h0004, 16'h0000);
    endtask
    task automatic t_pingpong;
        bw(ra(3, DCC_OFS_STAL), 16'h0100);
        bw(ra(3, DCC_OFS_STBL), 16'h0200);
        bw(ra(3, DCC_OFS_CON), 16'h8002);
        frc(3, 24'h00_0100);
        br(DCC_OFS_PPST);
        chk("ppst", 32'(rd), 32'h0000_0008);
        frc(3, 24'h00_0200);
        frc(3, 24'h00_0100);
        bw(ra(3, DCC_OFS_CON), 16'h8003);
        frc(3, 24'h00_0100);
        frc(3, 24'h00_0200);
        br(ra(3, DCC_OFS_CON));
        chk("con", 32'(rd), 32'h0000_0003);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog
    task automatic print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        t_reset();
        t_fields();
        t_oneshot();
        t_force();
        t_half();
        t_prio();
        t_pingpong();
        print_verdict();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
